// [core/pointer_offset_set_cmds.sv]
// Functional notes
// RULE1: Set-pointer loads pointer with parameters plus local offset.
// RULE2: Relative set-pointer adds parameters to current pointer.
// RULE3: Set-offset loads local offset with absolute parameters.
// RULE4: Relative set-offset adds parameters to local offset.
// RULE5: Local offset is added to every later command coordinate.
// RULE6: Offset change leaves pointer alone; software reissues set-pointer.
// RULE7: Pointer serves only relative drawing; absolute uses own parameters.
// RULE8: Absolute drawing may clobber pointer; software reissues set-pointer.
// RULE9: Draw-mode bits of these commands must be zero.
// RULE10: All coordinate and offset parameters are signed two's complement.
// RULE11: Offset undefined after reset; software sets it first.
// RULE12: With fast four-pixel use, absolute offset X is multiple of four.
// RULE13: With fast four-pixel use, relative result offset X multiple of four.
// RULE14: Software keeps both offset components non-negative.
// RULE15: Relative drawing end stores final vertex into pointer.
// RULE16: Opcode in bits 15:11, mode 10:0, two parameter words follow.
// RULE17: Commands complete in list order before later commands see values.
`include "ptr_ofs_map.svh"
`default_nettype none
module pointer_offset_set_cmds (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wordValid,
    input wire logic [15:0] wordData,
    output logic wordReady,
    output logic cmdDone,
    output logic modeError,
    input wire logic drawWrite,
    input wire logic signed [15:0] drawX,
    input wire logic signed [15:0] drawY,
    output logic signed [15:0] currentPointerX,
    output logic signed [15:0] currentPointerY,
    output logic signed [15:0] localOffsetX,
    output logic signed [15:0] localOffsetY
);

    // Decoder half of the coordinate bus; the registers sit in coord_regs
    coord_bus_if cb();

    // Word walker state
    ptr_ofs_pkg::state_t state_q;
    ptr_ofs_pkg::state_t state_d;
    ptr_ofs_pkg::action_t act_q;
    ptr_ofs_pkg::action_t act_d;
    ptr_ofs_pkg::coord_t parX_q;
    ptr_ofs_pkg::coord_t parX_d;

    // Status seen by the list fetcher
    logic done_q;
    logic done_d;
    logic err_q;
    logic err_d;
    logic ready_q;
    logic ready_d;

    // Handshake and decode
    logic take;
    logic takeCmd;
    logic takeParX;
    logic takeParY;
    logic [4:0] opcode;
    logic [10:0] modeBits;
    wire [10:0] modeSet;
    logic modeAny;
    ptr_ofs_pkg::action_t cmdAction;

    // Unknown opcodes still eat two parameter words, so the list stays aligned
    function automatic ptr_ofs_pkg::action_t decode_op(input logic [4:0] op);
        ptr_ofs_pkg::action_t act;
        // Only the opcode field matters; the mode field is flagged elsewhere
        case (op)
            `OPC_SET_POINTER_ABS: begin
                act = ptr_ofs_pkg::ACT_PTR_ABS;
            end

            `OPC_SET_POINTER_REL: begin
                act = ptr_ofs_pkg::ACT_PTR_REL;
            end

            `OPC_SET_OFFSET_ABS: begin
                act = ptr_ofs_pkg::ACT_OFS_ABS;
            end

            `OPC_SET_OFFSET_REL: begin
                act = ptr_ofs_pkg::ACT_OFS_REL;
            end

            default: begin
                act = ptr_ofs_pkg::ACT_NONE;
            end
        endcase
        return act;
    endfunction

    // A word moves on every edge where valid meets ready
    assign take = wordValid && ready_q;
    assign takeCmd = take && (state_q == ptr_ofs_pkg::ST_IDLE);
    assign takeParX = take && (state_q == ptr_ofs_pkg::ST_PARAM_X);
    assign takeParY = take && (state_q == ptr_ofs_pkg::ST_PARAM_Y);
    assign opcode = wordData[`OPC_MSB:`OPC_LSB]; // RULE16
    assign modeBits = wordData[`MODE_MSB:0]; // RULE16
    assign cmdAction = decode_op(opcode); // RULE16

    // Reserved mode bits are flagged, not refused: the command still runs
    genvar b;
    generate
        for (b = 0; b <= `MODE_MSB; b = b + 1) begin : g_mode
            assign modeSet[b] = takeCmd && modeBits[b]; // RULE9
        end
    endgenerate
    assign modeAny = |modeSet; // RULE9

    // Walker: command word, X, then Y; X waits here until Y arrives
    always_comb begin
        state_d = state_q;
        act_d = act_q;
        parX_d = parX_q;
        case (state_q)
            ptr_ofs_pkg::ST_IDLE: begin
                if (takeCmd) begin
                    state_d = ptr_ofs_pkg::ST_PARAM_X;
                    act_d = cmdAction; // RULE16
                end
            end

            ptr_ofs_pkg::ST_PARAM_X: begin
                if (takeParX) begin
                    state_d = ptr_ofs_pkg::ST_PARAM_Y;
                    parX_d = wordData; // RULE10
                end
            end

            ptr_ofs_pkg::ST_PARAM_Y: begin
                if (takeParY) begin
                    state_d = ptr_ofs_pkg::ST_IDLE;
                    // Nothing pending once the update has gone out
                    act_d = ptr_ofs_pkg::ACT_NONE;
                end
            end

            default: begin
                state_d = ptr_ofs_pkg::ST_IDLE;
            end
        endcase
    end

    // Asynchronous clear; the held X word needs no particular value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ptr_ofs_pkg::ST_IDLE;
            act_q <= ptr_ofs_pkg::ACT_NONE;
            parX_q <= `COORD_RESET;
        end else begin
            state_q <= state_d;
            act_q <= act_d;
            parX_q <= parX_d;
        end
    end

    // Status: done pulse, reserved-bit flag and ready
    always_comb begin
        // Ready never drops: every word is consumed in the cycle it is offered
        ready_d = 1'b1;
        done_d = 1'b0;
        if (takeParY) begin
            done_d = 1'b1; // RULE17
        end
        if (takeCmd) begin
            err_d = modeAny; // RULE9
        end else begin
            err_d = err_q;
        end
    end

    // Ready comes up one edge after reset lets go
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            done_q <= done_d;
            err_q <= err_d;
            ready_q <= ready_d;
        end
    end

    // The update lands on the Y edge, ahead of any following command word
    always_comb begin
        if (takeParY) begin
            cb.apply = 1'b1; // RULE17
        end else begin
            cb.apply = 1'b0;
        end
        cb.action = act_q;
        cb.paramX = parX_q; // RULE10
        // Y goes straight from the word to save a holding register
        cb.paramY = wordData; // RULE10
    end

    // Pointer and offset registers, and the drawing engine's write port
    coord_regs regs (
        .clk(clk),
        .rst_b(rst_b),
        .drawWrite(drawWrite),
        .drawX(drawX),
        .drawY(drawY),
        .cb(cb)
    );

    // Drawing engine adds offsets itself; pointer only read for relative draws
    assign wordReady = ready_q;
    assign cmdDone = done_q;
    assign modeError = err_q;
    assign currentPointerX = cb.ptrX; // RULE7
    assign currentPointerY = cb.ptrY; // RULE7
    assign localOffsetX = cb.ofsX; // RULE5
    assign localOffsetY = cb.ofsY; // RULE5
endmodule
`default_nettype wire

// [inc/ptr_ofs_map.svh]
`ifndef PTR_OFS_MAP_SVH
`define PTR_OFS_MAP_SVH
`define OPC_SET_POINTER_ABS 5'h10
`define OPC_SET_POINTER_REL 5'h11
`define OPC_SET_OFFSET_ABS 5'h12
`define OPC_SET_OFFSET_REL 5'h13
`define OPC_MSB 15
`define OPC_LSB 11
`define MODE_MSB 10
`define COORD_RESET 16'h0000
`endif

// [inc/ptr_ofs_pkg.sv]
`default_nettype none
package ptr_ofs_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PARAM_X = 2'b01,
        ST_PARAM_Y = 2'b10
    } state_t;
    typedef enum logic [2:0] {
        ACT_NONE = 3'b000,
        ACT_PTR_ABS = 3'b001,
        ACT_PTR_REL = 3'b010,
        ACT_OFS_ABS = 3'b011,
        ACT_OFS_REL = 3'b100
    } action_t;
    typedef logic signed [15:0] coord_t;
endpackage
`default_nettype wire

// [inc/coord_bus_if.sv]
`default_nettype none
interface coord_bus_if;
    logic signed [15:0] paramX;
    logic signed [15:0] paramY;
    logic [2:0] action;
    logic apply;
    logic signed [15:0] ptrX;
    logic signed [15:0] ptrY;
    logic signed [15:0] ofsX;
    logic signed [15:0] ofsY;
    modport decoder (output paramX, paramY, action, apply, input ptrX, ptrY, ofsX, ofsY);
    modport regs (input paramX, paramY, action, apply, output ptrX, ptrY, ofsX, ofsY);
endinterface
`default_nettype wire

// [core/coord_regs.sv]
`include "ptr_ofs_map.svh"
`default_nettype none
module coord_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic drawWrite,
    input wire logic signed [15:0] drawX,
    input wire logic signed [15:0] drawY,
    coord_bus_if.regs cb
);
    ptr_ofs_pkg::coord_t ptrX_q, ptrX_d, ptrY_q, ptrY_d, ofsX_q, ofsX_d, ofsY_q, ofsY_d;
    always_comb begin
        ptrX_d = ptrX_q;
        ptrY_d = ptrY_q;
        ofsX_d = ofsX_q;
        ofsY_d = ofsY_q;
        if (cb.apply) begin
            case (ptr_ofs_pkg::action_t'(cb.action))
                ptr_ofs_pkg::ACT_PTR_ABS: begin
                    ptrX_d = cb.paramX + ofsX_q; // RULE1
                    ptrY_d = cb.paramY + ofsY_q; // RULE1
                end
                ptr_ofs_pkg::ACT_PTR_REL: begin
                    ptrX_d = ptrX_q + cb.paramX; // RULE2
                    ptrY_d = ptrY_q + cb.paramY; // RULE2
                end
                ptr_ofs_pkg::ACT_OFS_ABS: begin
                    // Pointer left alone on offset changes
                    ofsX_d = cb.paramX; // RULE3 RULE6
                    ofsY_d = cb.paramY; // RULE3
                end
                ptr_ofs_pkg::ACT_OFS_REL: begin
                    ofsX_d = ofsX_q + cb.paramX; // RULE4
                    ofsY_d = ofsY_q + cb.paramY; // RULE4
                end
                default: begin
                end
            endcase
        end else if (drawWrite) begin
            // Drawing engine final vertex or scratch use
            ptrX_d = drawX; // RULE15 RULE8
            ptrY_d = drawY; // RULE15 RULE8
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptrX_q <= `COORD_RESET;
            ptrY_q <= `COORD_RESET;
            ofsX_q <= `COORD_RESET;
            ofsY_q <= `COORD_RESET;
        end else begin
            ptrX_q <= ptrX_d;
            ptrY_q <= ptrY_d;
            ofsX_q <= ofsX_d;
            ofsY_q <= ofsY_d;
        end
    end
    assign cb.ptrX = ptrX_q;
    assign cb.ptrY = ptrY_q;
    assign cb.ofsX = ofsX_q;
    assign cb.ofsY = ofsY_q;
endmodule
`default_nettype wire

// [verification/pointer_offset_set_cmds_properties.sv]
`default_nettype none
module ptr_ofs_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wordValid,
    input wire logic [15:0] wordData,
    input wire logic wordReady,
    input wire logic cmdDone,
    input wire logic modeError,
    input wire logic drawWrite,
    input wire logic signed [15:0] drawX,
    input wire logic signed [15:0] currentPointerX,
    input wire logic signed [15:0] currentPointerY,
    input wire logic signed [15:0] localOffsetX,
    input wire logic signed [15:0] localOffsetY
);
    logic [1:0] ph_q, ph_d;
    logic [4:0] op_q, op_d;
    logic [15:0] px_q, px_d;
    logic tk, t2;
    logic [10:0] md;
    assign tk = wordValid && wordReady;
    assign t2 = tk && ph_q == 2'h2;
    assign md = wordData[10:0];
    always_comb begin
        ph_d = tk ? (t2 ? 2'h0 : ph_q + 2'h1) : ph_q;
        op_d = (tk && ph_q == 2'h0) ? wordData[15:11] : op_q;
        px_d = (tk && ph_q == 2'h1) ? wordData : px_q;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 2'h0;
            op_q <= 5'h0;
            px_q <= 16'h0;
        end else begin
            ph_q <= ph_d;
            op_q <= op_d;
            px_q <= px_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_done_on_y: assert property (t2 |=> cmdDone) else $error("done late");
    a_ptr_abs: assert property (t2 && op_q == 5'h10 |=>
        currentPointerX == $past(px_q) + $past(localOffsetX)
        && currentPointerY == $past(wordData) + $past(localOffsetY))
        else $error("abs pointer");
    a_ptr_rel: assert property (t2 && op_q == 5'h11 |=>
        currentPointerX == $past(px_q) + $past(currentPointerX)
        && currentPointerY == $past(wordData) + $past(currentPointerY))
        else $error("rel pointer");
    a_ofs_abs: assert property (t2 && op_q == 5'h12 |=>
        localOffsetX == $past(px_q) && localOffsetY == $past(wordData))
        else $error("abs offset");
    a_ofs_rel: assert property (t2 && op_q == 5'h13 |=>
        localOffsetX == $past(px_q) + $past(localOffsetX)
        && localOffsetY == $past(wordData) + $past(localOffsetY))
        else $error("rel offset");
    a_ofs_keeps_ptr: assert property (t2 && op_q[4:1] == 4'h9 |=>
        $stable(currentPointerX) && $stable(currentPointerY)) else $error("pointer moved");
    a_skip_keeps: assert property (t2 && op_q[4:2] != 3'h4 |=>
        $stable(currentPointerX) && $stable(localOffsetX)) else $error("skip changed state");
    a_mode_flag: assert property (tk && ph_q == 2'h0 |=>
        modeError == ($past(md) != 11'h0)) else $error("mode flag");
    a_draw_store: assert property (drawWrite && !tk |=>
        currentPointerX == $past(drawX)) else $error("draw store");
    c_ptr_abs: cover property (t2 && op_q == 5'h10);
    c_ofs_rel: cover property (t2 && op_q == 5'h13);
    c_skip: cover property (t2 && op_q[4:2] != 3'h4);
    c_draw: cover property (drawWrite && !tk);
    c_mode: cover property (modeError);
endmodule
`default_nettype wire

// [verification/list_source.sv]
`default_nettype none
module list_source (
    input wire logic clk,
    input wire logic wordReady,
    output logic wordValid,
    output logic [15:0] wordData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] q[$];
    logic slow = 1'b0;
    logic took;
    initial begin
        wordValid = 1'b0;
        wordData = 16'h0;
    end
    // Idle data flips each cycle so a stale word can never pass for a fresh one
    always @(posedge clk) begin
        took = wordValid && wordReady;
        if (took) void'(q.pop_front());
        #1;
        if (q.size() > 0 && !(slow && took)) begin
            wordValid = 1'b1;
            wordData = q[0];
        end else begin
            wordValid = 1'b0;
            wordData = ~wordData;
        end
    end
endmodule
`default_nettype wire

// [verification/pointer_offset_set_cmds_tb.sv]
`default_nettype none
module pointer_offset_set_cmds_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic drawWrite = 1'b0;
    logic signed [15:0] drawX = 16'h0, drawY = 16'h0, ex = 16'h0, ey = 16'h0, ox, oy;
    logic wordValid, wordReady, cmdDone, modeError;
    logic [15:0] wordData;
    logic signed [15:0] ptrX, ptrY, ofsX, ofsY;
    int error_cnt = 0, checks_done = 0;
    always #20 clk = ~clk;
    list_source src (.clk(clk), .wordReady(wordReady), .wordValid(wordValid), .wordData(wordData));
    pointer_offset_set_cmds u_dut (.clk(clk), .rst_b(rst_b), .wordValid(wordValid),
        .wordData(wordData), .wordReady(wordReady), .cmdDone(cmdDone), .modeError(modeError),
        .drawWrite(drawWrite), .drawX(drawX), .drawY(drawY), .currentPointerX(ptrX),
        .currentPointerY(ptrY), .localOffsetX(ofsX), .localOffsetY(ofsY));
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task run(input logic [4:0] op, input logic [10:0] md,
        input logic [15:0] x, input logic [15:0] y);
        int n;
        n = 0;
        src.q.push_back({op, md});
        src.q.push_back(x);
        src.q.push_back(y);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cmdDone !== 1'b1 && n < 30);
        chk("done", {15'h0, cmdDone}, 16'h1);
        chk("mode", {15'h0, modeError}, {15'h0, md != 11'h0});
        if (op == 5'h10) {ex, ey} = {x + ox, y + oy};
        if (op == 5'h11) {ex, ey} = {ex + x, ey + y};
        if (op == 5'h12) {ox, oy} = {x, y};
        if (op == 5'h13) {ox, oy} = {ox + x, oy + y};
        chk("ptrX", ptrX, ex);
        chk("ptrY", ptrY, ey);
        chk("ofsX", ofsX, ox);
        chk("ofsY", ofsY, oy);
    endtask
    task t_offsets;
        run(5'h12, 11'h0, 16'h0008, 16'h0004);
        run(5'h10, 11'h0, 16'hfffd, 16'h0005);
        run(5'h11, 11'h0, 16'h0002, 16'hfff9);
        run(5'h13, 11'h0, 16'h0004, 16'h0002);
        run(5'h10, 11'h0, 16'h0000, 16'h0000);
    endtask
    // Drawing engine writes the last vertex; relative moves must start from it
    task t_draw;
        {drawWrite, drawX, drawY} = {1'b1, 16'h0064, 16'hffec};
        @(posedge clk);
        #1;
        {ex, ey} = {16'h0064, 16'hffec};
        chk("drawX", ptrX, ex);
        chk("drawY", ptrY, ey);
        // Draw write left high: the command's own update must win its cycle
        run(5'h11, 11'h0, 16'h0001, 16'h0001);
        drawWrite = 1'b0;
    endtask
    task t_mode;
        run(5'h10, 11'h400, 16'h0001, 16'h0001);
        run(5'h11, 11'h0, 16'h0001, 16'h0001);
        run(5'h1f, 11'h0, 16'h1234, 16'h5678);
    endtask
    task t_slow;
        src.slow = 1'b1;
        run(5'h12, 11'h0, 16'h0000, 16'h0000);
        run(5'h11, 11'h0, 16'hffff, 16'h0003);
        src.slow = 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk("rdyRst", {15'h0, wordReady}, 16'h0);
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        chk("rdyUp", {15'h0, wordReady}, 16'h1);
        t_offsets;
        t_draw;
        t_mode;
        t_slow;
        final_report;
    end
    initial begin
        #200000;
        error_cnt++;
        final_report;
    end
endmodule
bind pointer_offset_set_cmds ptr_ofs_checker u_chk (.clk(clk), .rst_b(rst_b),
    .wordValid(wordValid), .wordData(wordData), .wordReady(wordReady), .cmdDone(cmdDone),
    .modeError(modeError), .drawWrite(drawWrite), .drawX(drawX),
    .currentPointerX(currentPointerX), .currentPointerY(currentPointerY),
    .localOffsetX(localOffsetX), .localOffsetY(localOffsetY));
`default_nettype wire
